// ===== eps_regs.svh
`ifndef EPS_REGS_SVH
`define EPS_REGS_SVH

// control-and-acknowledge registers
`define EPS_HUB0_CTL_ADDR  16'h1fa7
`define EPS_FUN0_CTL_ADDR  16'h1fdd
`define EPS_FUN1_CTL_ADDR  16'h1fdb
`define EPS_FUN2_CTL_ADDR  16'h1fda
// service status registers
`define EPS_HUB0_STAT_ADDR 16'h1fa6
`define EPS_FUN0_STAT_ADDR 16'h1fdc
`define EPS_FUN1_STAT_ADDR 16'h1fd9
`define EPS_FUN2_STAT_ADDR 16'h1fd8

// field positions of the stored control nibble (register bits 7..4)
`define EPS_CTL_DIR        3
`define EPS_CTL_DATA_END   2
`define EPS_CTL_STALL      1
`define EPS_CTL_TX_RDY     0
// field positions of the status nibble
`define EPS_ST_STALL_SENT  3
`define EPS_ST_SETUP       2
`define EPS_ST_RX_OUT      1
`define EPS_ST_TRANSMIT_COMPLETE_FLAG    0

// reset and forced values, and write masks
`define EPS_STAT_RST       4'h0
`define EPS_CTL_RST        4'h0
`define EPS_STAT_SETUP     4'h4
`define EPS_DATA_CTL_MASK  4'h7
`define EPS_DATA_ACK_MASK  4'hb
`define EPS_CTRL_MASK      4'hf

`endif

// ===== eps_pkg.sv
`default_nettype none
package eps_pkg;

  typedef enum logic [1:0] {
    eps_tok_setup,
    eps_tok_out,
    eps_tok_in
  } eps_tok_t;

  typedef enum logic [2:0] {
    eps_ev_setup,
    eps_ev_out,
    eps_ev_in_ack,
    eps_ev_in_iso,
    eps_ev_stall
  } eps_ev_t;

  typedef enum logic [2:0] {
    eps_resp_ack,
    eps_resp_nak,
    eps_resp_stall,
    eps_resp_data,
    eps_resp_zlp1
  } eps_resp_t;

  typedef enum logic [1:0] {
    eps_ph_idle,
    eps_ph_data,
    eps_ph_status
  } eps_phase_t;

  typedef struct packed {
    logic [3:0][3:0]   stat;
    logic [3:0][3:0]   ctl;
    eps_phase_t [1:0]  ph;
    logic              resp_valid;
    eps_resp_t         resp_code;
    logic [3:0]        irq;
    logic [7:0]        rdata;
  } eps_state_t;

endpackage
`default_nettype wire

// ===== eps_endpoint_service.sv
// Notes on behaviour
// - a stall handshake sent to the host sets the halt-sent status bit 3
// - a stored setup on a control endpoint sets bit 2 and clears the others
// - setting the setup flag interrupts firmware when the endpoint interrupt is enabled
// - stored out data sets bit 1; further out tokens get nak meanwhile
// - pending out data stays intact except for an early setup
// - setting the out flag interrupts when enabled; firmware acknowledges after reading
// - control endpoint sets bit 0 after the last read packet, no-data status, write status
// - data endpoints set transmit-complete when an in transaction succeeds
// - writing one to acknowledge bits 3..0 clears the flag; nothing stored
// - firmware direction bit picks the status phase: 0 write/no data, 1 read
// - data end with transmit-ready moves to status after the current packet
// - finishing the status phase interrupts and leaves data end set
// - force stall on a control endpoint stalls in, out and no-data transfers
// - data endpoint force stall answers the next in or out with stall
// - transmit-ready clears on host ack, or with no ack after iso send on a data endpoint whose ep_iso bit is set
// - hardware clearing transmit-ready with transmit-complete set interrupts when enabled
// - status phase of a control endpoint is a data1 in when ready clear, end set, direction 0
// - out flag serves control write data and the data1 out status stage
// - reserved status bits 7..4 and other reserved positions read zero
`timescale 1ns/100ps
`default_nettype none
`include "eps_regs.svh"

module eps_endpoint_service
  import eps_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // firmware register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  // token decisions from the serial engine
  input  wire logic        tok_valid,
  input  wire logic [1:0]  tok_ep,
  input  wire eps_tok_t    tok_kind,
  output var  logic        resp_valid,
  output var  eps_resp_t   resp_code,
  // completed transaction events
  input  wire logic        ev_valid,
  input  wire logic [1:0]  ev_ep,
  input  wire eps_ev_t     ev_kind,
  // endpoint configuration held elsewhere
  input  wire logic [1:0]  ep_iso,
  input  wire logic [3:0]  ep_int_en,
  // interrupt requests, one per endpoint
  output var  logic [3:0]  ep_irq
);

  // endpoint 0 is the hub control endpoint, 1 the function control endpoint, 2 and 3 data endpoints
  localparam logic [3:0][15:0] ctl_addr = {`EPS_FUN2_CTL_ADDR, `EPS_FUN1_CTL_ADDR,
                                           `EPS_FUN0_CTL_ADDR, `EPS_HUB0_CTL_ADDR};
  localparam logic [3:0][15:0] stat_addr = {`EPS_FUN2_STAT_ADDR, `EPS_FUN1_STAT_ADDR,
                                            `EPS_FUN0_STAT_ADDR, `EPS_HUB0_STAT_ADDR};

  eps_state_t q;
  eps_state_t d;
  logic [3:0] wr_ctl;
  logic [3:0] rd_ctl;
  logic [3:0] rd_stat;

  always_comb begin
    for (int g = 0; g < 4; g++) begin
      wr_ctl[g]  = reg_wr && (reg_addr == ctl_addr[g]);
      rd_ctl[g]  = reg_rd && (reg_addr == ctl_addr[g]);
      rd_stat[g] = reg_rd && (reg_addr == stat_addr[g]);
    end
  end

  function automatic eps_resp_t answer(input logic [1:0] ep, input eps_tok_t kind,
                                       input logic [3:0] ctl, input logic [3:0] st);
    logic is_ctrl;
    eps_resp_t r;
    is_ctrl = (ep < 2'd2);
    r = eps_resp_nak;
    if (kind == eps_tok_setup) begin
      // an early setup is taken even with out data pending; it may overwrite the buffer
      r = is_ctrl ? eps_resp_ack : eps_resp_nak;
    end else if (ctl[`EPS_CTL_STALL]) begin
      r = eps_resp_stall;
    end else if (kind == eps_tok_out) begin
      r = st[`EPS_ST_RX_OUT] ? eps_resp_nak : eps_resp_ack;
    end else if (ctl[`EPS_CTL_TX_RDY]) begin
      r = eps_resp_data;
    end else if (is_ctrl && ctl[`EPS_CTL_DATA_END] && !ctl[`EPS_CTL_DIR]) begin
      r = eps_resp_zlp1;
    end
    return r;
  endfunction

  always_comb begin
    logic [3:0] mask;
    logic       is_ctrl;
    mask = `EPS_CTRL_MASK;
    is_ctrl = 1'b0;
    d = q;
    d.resp_valid = 1'b0;
    d.irq = 4'h0;
    d.rdata = 8'h00;

    // acknowledge clears come first so that a set in the same cycle wins
    for (int g = 0; g < 4; g++) begin
      if (wr_ctl[g]) begin
        mask = (g >= 2) ? `EPS_DATA_ACK_MASK : `EPS_CTRL_MASK;
        d.stat[g] = d.stat[g] & ~(reg_wdata[3:0] & mask);
      end
    end

    if (ev_valid) begin
      is_ctrl = (ev_ep < 2'd2);
      case (ev_kind)
        eps_ev_setup: begin
          if (is_ctrl) begin
            d.stat[ev_ep] = `EPS_STAT_SETUP;
            d.ph[ev_ep[0]] = eps_ph_data;
            d.irq[ev_ep] = ep_int_en[ev_ep];
          end
        end
        eps_ev_out: begin
          d.stat[ev_ep][`EPS_ST_RX_OUT] = 1'b1;
          d.irq[ev_ep] = ep_int_en[ev_ep];
          if (is_ctrl && q.ph[ev_ep[0]] == eps_ph_status) begin
            d.ph[ev_ep[0]] = eps_ph_idle;
          end
        end
        eps_ev_in_ack: begin
          if (q.ctl[ev_ep][`EPS_CTL_TX_RDY]) begin
            d.ctl[ev_ep][`EPS_CTL_TX_RDY] = 1'b0;
            if (!is_ctrl) begin
              d.stat[ev_ep][`EPS_ST_TRANSMIT_COMPLETE_FLAG] = 1'b1;
              d.irq[ev_ep] = ep_int_en[ev_ep];
            end else if (q.ctl[ev_ep][`EPS_CTL_DATA_END]) begin
              // last packet of a control read: the host status out follows
              d.stat[ev_ep][`EPS_ST_TRANSMIT_COMPLETE_FLAG] = 1'b1;
              d.ph[ev_ep[0]] = eps_ph_status;
              d.irq[ev_ep] = ep_int_en[ev_ep];
            end else begin
              // an earlier completion that firmware has not acknowledged still interrupts on this clear
              d.irq[ev_ep] = ep_int_en[ev_ep] & d.stat[ev_ep][`EPS_ST_TRANSMIT_COMPLETE_FLAG];
            end
          end else if (is_ctrl) begin
            // zero-length data1 status in acknowledged; data end is left as it is
            d.stat[ev_ep][`EPS_ST_TRANSMIT_COMPLETE_FLAG] = 1'b1;
            d.ph[ev_ep[0]] = eps_ph_idle;
            d.irq[ev_ep] = ep_int_en[ev_ep];
          end
        end
        eps_ev_in_iso: begin
          if (!is_ctrl && ep_iso[ev_ep[0]]) begin
            d.ctl[ev_ep][`EPS_CTL_TX_RDY] = 1'b0;
            d.stat[ev_ep][`EPS_ST_TRANSMIT_COMPLETE_FLAG] = 1'b1;
            d.irq[ev_ep] = ep_int_en[ev_ep];
          end
        end
        eps_ev_stall: begin
          d.stat[ev_ep][`EPS_ST_STALL_SENT] = 1'b1;
        end
        default: begin
          d.irq = 4'h0;
        end
      endcase
    end

    // firmware writes to the stored control bits override a hardware clear in the same cycle
    for (int g = 0; g < 4; g++) begin
      if (wr_ctl[g]) begin
        mask = (g >= 2) ? `EPS_DATA_CTL_MASK : `EPS_CTRL_MASK;
        d.ctl[g] = reg_wdata[7:4] & mask;
      end
    end

    if (tok_valid) begin
      d.resp_valid = 1'b1;
      d.resp_code = answer(tok_ep, tok_kind, q.ctl[tok_ep], q.stat[tok_ep]);
    end

    // acknowledge bits are never stored, so they read back as zero
    for (int g = 0; g < 4; g++) begin
      if (rd_ctl[g]) begin
        d.rdata = {q.ctl[g], 4'h0};
      end
      if (rd_stat[g]) begin
        d.rdata = {4'h0, q.stat[g]};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q.stat       <= {4{`EPS_STAT_RST}};
      q.ctl        <= {4{`EPS_CTL_RST}};
      q.ph         <= '{eps_ph_idle, eps_ph_idle};
      q.resp_valid <= 1'b0;
      q.resp_code  <= eps_resp_nak;
      q.irq        <= 4'h0;
      q.rdata      <= 8'h00;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata  = q.rdata;
  assign resp_valid = q.resp_valid;
  assign resp_code  = q.resp_code;
  assign ep_irq     = q.irq;

  for (genvar g = 0; g < 4; g++) begin : g_chk
    a_stall_sent_flag: assert property (
      @(posedge clock) disable iff (!rstn)
      (ev_valid && ev_ep == g && ev_kind == eps_ev_stall) |=> q.stat[g][`EPS_ST_STALL_SENT])
      else $error("stall sent flag not set");

    if (g < 2) begin : g_ctrl
      a_setup_clears_rest: assert property (
        @(posedge clock) disable iff (!rstn)
        (ev_valid && ev_ep == g && ev_kind == eps_ev_setup) |=> (q.stat[g] == 4'h4))
        else $error("setup did not leave only the setup flag");

      a_setup_irq_pulse: assert property (
        @(posedge clock) disable iff (!rstn)
        (ev_valid && ev_ep == g && ev_kind == eps_ev_setup && ep_int_en[g]) |=> ep_irq[g] ##1 !ep_irq[g])
        else $error("setup interrupt missing or too long");

      a_zlp_status_in: assert property (
        @(posedge clock) disable iff (!rstn)
        (tok_valid && tok_ep == g && tok_kind == eps_tok_in && q.ctl[g] == 4'h4)
        |=> (resp_valid && resp_code == eps_resp_zlp1))
        else $error("status in not answered with data1 zero length");

      a_status_keeps_end: assert property (
        @(posedge clock) disable iff (!rstn)
        (ev_valid && ev_ep == g && ev_kind == eps_ev_in_ack && !q.ctl[g][0] && q.ctl[g][2] && !wr_ctl[g])
        |=> (q.stat[g][0] && q.ctl[g][2] && ep_irq[g] == $past(ep_int_en[g])))
        else $error("status completion lost data end or interrupt");

      a_enter_status_ph: assert property (
        @(posedge clock) disable iff (!rstn)
        (ev_valid && ev_ep == g && ev_kind == eps_ev_in_ack && q.ctl[g][0] && q.ctl[g][2] && !wr_ctl[g])
        |=> (q.ph[g] == eps_ph_status && !q.ctl[g][0] && q.stat[g][0]))
        else $error("last read packet did not enter the status phase");

      a_ctrl_clear_irq: assert property (
        @(posedge clock) disable iff (!rstn)
        (ev_valid && ev_ep == g && ev_kind == eps_ev_in_ack && q.ctl[g][0] && !q.ctl[g][2]
         && q.stat[g][0] && !wr_ctl[g])
        |=> (!q.ctl[g][0] && ep_irq[g] == $past(ep_int_en[g])))
        else $error("ready clear with completion pending did not interrupt");

      a_setup_taken: assert property (
        @(posedge clock) disable iff (!rstn)
        (tok_valid && tok_ep == g && tok_kind == eps_tok_setup)
        |=> (resp_valid && resp_code == eps_resp_ack))
        else $error("setup token not accepted");

      a_read_dir_nak: assert property (
        @(posedge clock) disable iff (!rstn)
        (tok_valid && tok_ep == g && tok_kind == eps_tok_in && q.ctl[g] == 4'hc)
        |=> (resp_valid && resp_code == eps_resp_nak))
        else $error("control read status offered an in packet");

      a_status_out_done: assert property (
        @(posedge clock) disable iff (!rstn)
        (ev_valid && ev_ep == g && ev_kind == eps_ev_out && q.ph[g] == eps_ph_status)
        |=> (q.ph[g] == eps_ph_idle && q.stat[g][1]))
        else $error("status out did not close the transfer");
    end else begin : g_data
      a_in_done_flag: assert property (
        @(posedge clock) disable iff (!rstn)
        (ev_valid && ev_ep == g && ev_kind == eps_ev_in_ack && q.ctl[g][0] && !wr_ctl[g])
        |=> (q.stat[g][0] && !q.ctl[g][0]))
        else $error("in completion did not update flags");

      a_setup_data_skip: assert property (
        @(posedge clock) disable iff (!rstn)
        (ev_valid && ev_ep == g && ev_kind == eps_ev_setup && !wr_ctl[g])
        |=> (q.stat[g] == $past(q.stat[g]) && !ep_irq[g]))
        else $error("setup changed a data endpoint");

      a_iso_clears_ready: assert property (
        @(posedge clock) disable iff (!rstn)
        (ev_valid && ev_ep == g && ev_kind == eps_ev_in_iso && ep_iso[g-2] && !wr_ctl[g])
        |=> (!q.ctl[g][0] && q.stat[g][0]))
        else $error("iso send did not clear ready");

      a_data_dir_zero: assert property (
        @(posedge clock) disable iff (!rstn)
        wr_ctl[g]
        |=> !q.ctl[g][3])
        else $error("reserved control bit stored");
    end

    a_out_nak_pending: assert property (
      @(posedge clock) disable iff (!rstn)
      (tok_valid && tok_ep == g && tok_kind == eps_tok_out && q.stat[g][1] && !q.ctl[g][1])
      |=> (resp_valid && resp_code == eps_resp_nak))
      else $error("out token not refused while data pending");

    a_force_stall_resp: assert property (
      @(posedge clock) disable iff (!rstn)
      (tok_valid && tok_ep == g && tok_kind != eps_tok_setup && q.ctl[g][1])
      |=> (resp_valid && resp_code == eps_resp_stall))
      else $error("forced stall not answered with stall");

    a_ack_clears_flag: assert property (
      @(posedge clock) disable iff (!rstn)
      (wr_ctl[g] && reg_wdata[0] && !(ev_valid && ev_ep == g))
      |=> (!q.stat[g][0] ##1 !(reg_rdata[3:0] != 4'h0 && $past(rd_ctl[g]))))
      else $error("acknowledge did not clear or was stored");

    a_set_beats_ack: assert property (
      @(posedge clock) disable iff (!rstn)
      (wr_ctl[g] && reg_wdata[1] && ev_valid && ev_ep == g && ev_kind == eps_ev_out)
      |=> q.stat[g][1])
      else $error("event lost against acknowledge");

    a_out_irq_pulse: assert property (
      @(posedge clock) disable iff (!rstn)
      (ev_valid && ev_ep == g && ev_kind == eps_ev_out) |=> (ep_irq[g] == $past(ep_int_en[g])))
      else $error("out interrupt does not follow enable");

    a_ready_sends_data: assert property (
      @(posedge clock) disable iff (!rstn)
      (tok_valid && tok_ep == g && tok_kind == eps_tok_in && q.ctl[g][1:0] == 2'b01)
      |=> (resp_valid && resp_code == eps_resp_data))
      else $error("ready packet not offered on in token");

    a_out_ack_free: assert property (
      @(posedge clock) disable iff (!rstn)
      (tok_valid && tok_ep == g && tok_kind == eps_tok_out && !q.stat[g][1] && !q.ctl[g][1])
      |=> (resp_valid && resp_code == eps_resp_ack))
      else $error("out token refused with no data pending");

    a_irq_needs_en: assert property (
      @(posedge clock) disable iff (!rstn)
      !ep_int_en[g]
      |=> !ep_irq[g])
      else $error("interrupt raised while disabled");

    a_stall_no_irq: assert property (
      @(posedge clock) disable iff (!rstn)
      (ev_valid && ev_ep == g && ev_kind == eps_ev_stall)
      |=> !ep_irq[g])
      else $error("stall sent raised an interrupt");

    a_ctl_readback: assert property (
      @(posedge clock) disable iff (!rstn)
      rd_ctl[g]
      |=> (reg_rdata == {$past(q.ctl[g]), 4'h0}))
      else $error("control read back wrong or acknowledge stored");

    a_out_sets_flag: assert property (
      @(posedge clock) disable iff (!rstn)
      (ev_valid && ev_ep == g && ev_kind == eps_ev_out)
      |=> q.stat[g][1])
      else $error("stored out data did not set the flag");
  end

  a_rsvd_read_zero: assert property (
    @(posedge clock) disable iff (!rstn)
    (|rd_stat) |=> (reg_rdata[7:4] == 4'h0))
    else $error("reserved status bits not zero");

  a_rdata_idle: assert property (
    @(posedge clock) disable iff (!rstn)
    !reg_rd
    |=> (reg_rdata == 8'h00))
    else $error("read data shown outside a read");

endmodule
`default_nettype wire

// ===== eps_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module eps_host_model
  import eps_pkg::*;
(
  // clock
  input  wire logic       clock,
  // tokens and completed transactions
  output var  logic       tok_valid,
  output var  logic [1:0] tok_ep,
  output var  eps_tok_t   tok_kind,
  output var  logic       ev_valid,
  output var  logic [1:0] ev_ep,
  output var  eps_ev_t    ev_kind,
  // device answer
  input  wire logic       resp_valid,
  input  wire eps_resp_t  resp_code
);
  initial begin
    tok_valid = 1'b0;
    tok_ep = 2'h0;
    tok_kind = eps_tok_setup;
    ev_valid = 1'b0;
    ev_ep = 2'h0;
    ev_kind = eps_ev_setup;
  end
  // released endpoint fields show the inverse so a stale value is never mistaken for a live one; the kind fields keep their value
  task automatic token(input logic [1:0] ep, input eps_tok_t k, output logic v, output eps_resp_t r);
    @(posedge clock);
    tok_valid <= 1'b1;
    tok_ep <= ep;
    tok_kind <= k;
    @(posedge clock);
    tok_valid <= 1'b0;
    tok_ep <= ~ep;
    #1;
    v = resp_valid;
    r = resp_code;
  endtask
  task automatic send_ev(input logic [1:0] ep, input eps_ev_t k);
    @(posedge clock);
    ev_valid <= 1'b1;
    ev_ep <= ep;
    ev_kind <= k;
    @(posedge clock);
    ev_valid <= 1'b0;
    ev_ep <= ~ep;
    #1;
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "eps_regs.svh"
module testbench import eps_pkg::*;;
  typedef struct {logic [1:0] ep; eps_ev_t k; logic irq; logic [7:0] st;} eps_tb_row_t;
  logic        clock = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tok_valid, ev_valid, resp_valid;
  logic [15:0] reg_addr = 16'h0;
  logic [7:0]  reg_wdata = 8'h0, reg_rdata;
  logic [1:0]  tok_ep, ev_ep, ep_iso = 2'h0;
  logic [3:0]  ep_int_en = 4'hf, ep_irq;
  eps_tok_t    tok_kind;
  eps_ev_t     ev_kind;
  eps_resp_t   resp_code;
  int          err_count = 0, tests_run = 0;
  logic [15:0] st_a [4] = '{`EPS_HUB0_STAT_ADDR, `EPS_FUN0_STAT_ADDR, `EPS_FUN1_STAT_ADDR, `EPS_FUN2_STAT_ADDR};
  logic [15:0] ct_a [4] = '{`EPS_HUB0_CTL_ADDR, `EPS_FUN0_CTL_ADDR, `EPS_FUN1_CTL_ADDR, `EPS_FUN2_CTL_ADDR};
  eps_tb_row_t rows [8] = '{'{2'd0, eps_ev_setup, 1'b1, 8'h04}, '{2'd1, eps_ev_setup, 1'b1, 8'h04},
    '{2'd2, eps_ev_out, 1'b1, 8'h02}, '{2'd3, eps_ev_out, 1'b1, 8'h02}, '{2'd1, eps_ev_stall, 1'b0, 8'h08},
    '{2'd0, eps_ev_in_ack, 1'b1, 8'h01}, '{2'd3, eps_ev_setup, 1'b0, 8'h00}, '{2'd3, eps_ev_stall, 1'b0, 8'h08}};

  always #50 clock = ~clock;

  eps_endpoint_service i_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok_valid(tok_valid), .tok_ep(tok_ep),
    .tok_kind(tok_kind), .resp_valid(resp_valid), .resp_code(resp_code), .ev_valid(ev_valid), .ev_ep(ev_ep),
    .ev_kind(ev_kind), .ep_iso(ep_iso), .ep_int_en(ep_int_en), .ep_irq(ep_irq));
  eps_host_model i_host (.clock(clock), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_kind(tok_kind),
    .ev_valid(ev_valid), .ev_ep(ev_ep), .ev_kind(ev_kind), .resp_valid(resp_valid), .resp_code(resp_code));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic tok(input logic [1:0] ep, input eps_tok_t k, input eps_resp_t exp);
    logic      v;
    eps_resp_t r;
    i_host.token(ep, k, v, r);
    chk({v, 4'h0, r}, {1'b1, 4'h0, exp});
  endtask
  task automatic evchk(input logic [1:0] ep, input eps_ev_t k, input logic irq, input logic [7:0] st);
    i_host.send_ev(ep, k);
    chk({4'h0, ep_irq}, irq ? 8'h1 << ep : 8'h0);
    rd(st_a[ep], st);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clock);
    err_count++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk({resp_valid, ep_irq, resp_code}, {1'b0, 4'h0, eps_resp_nak});
    for (int i = 0; i < 4; i++) begin
      rd(st_a[i], 8'h00);
      rd(ct_a[i], 8'h00);
    end
    rd(16'h1fa0, 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      evchk(rows[i].ep, rows[i].k, rows[i].irq, rows[i].st);
      wr(ct_a[rows[i].ep], 8'h0f);
      rd(st_a[rows[i].ep], 8'h00);
    end
    $display("test table done");
    i_host.send_ev(3, eps_ev_out);
    tok(3, eps_tok_out, eps_resp_nak);
    wr(ct_a[3], 8'h02);
    rd(ct_a[3], 8'h00);
    tok(3, eps_tok_out, eps_resp_ack);
    $display("test out_nak done");
    i_host.send_ev(1, eps_ev_out);
    i_host.send_ev(1, eps_ev_stall);
    evchk(1, eps_ev_setup, 1'b1, 8'h04);
    tok(1, eps_tok_setup, eps_resp_ack);
    tok(2, eps_tok_setup, eps_resp_nak);
    wr(ct_a[1], 8'h04);
    rd(st_a[1], 8'h00);
    $display("test early_setup done");
    wr(ct_a[2], 8'ha0);
    rd(ct_a[2], 8'h20);
    tok(2, eps_tok_in, eps_resp_stall);
    tok(2, eps_tok_out, eps_resp_stall);
    wr(ct_a[0], 8'h20);
    tok(0, eps_tok_in, eps_resp_stall);
    tok(0, eps_tok_out, eps_resp_stall);
    wr(ct_a[0], 8'h00);
    wr(ct_a[2], 8'h10);
    tok(2, eps_tok_in, eps_resp_data);
    evchk(2, eps_ev_in_ack, 1'b1, 8'h01);
    rd(ct_a[2], 8'h00);
    wr(ct_a[2], 8'h01);
    $display("test stall_and_in done");
    wr(ct_a[1], 8'h50);
    evchk(1, eps_ev_in_ack, 1'b1, 8'h01);
    evchk(1, eps_ev_out, 1'b1, 8'h03);
    rd(ct_a[1], 8'h40);
    tok(1, eps_tok_in, eps_resp_zlp1);
    wr(ct_a[1], 8'h42);
    evchk(1, eps_ev_in_ack, 1'b1, 8'h01);
    rd(ct_a[1], 8'h40);
    wr(ct_a[1], 8'hc1);
    tok(1, eps_tok_in, eps_resp_nak);
    wr(ct_a[1], 8'h00);
    evchk(0, eps_ev_in_ack, 1'b1, 8'h01);
    wr(ct_a[0], 8'h10);
    evchk(0, eps_ev_in_ack, 1'b1, 8'h01);
    rd(ct_a[0], 8'h00);
    wr(ct_a[0], 8'h01);
    $display("test status_phase done");
    @(posedge clock);
    ep_iso <= 2'b01;
    wr(ct_a[2], 8'h10);
    evchk(2, eps_ev_in_iso, 1'b1, 8'h01);
    rd(ct_a[2], 8'h00);
    evchk(3, eps_ev_in_iso, 1'b0, 8'h00);
    wr(ct_a[2], 8'h01);
    @(posedge clock);
    ep_int_en <= 4'he;
    evchk(0, eps_ev_setup, 1'b0, 8'h04);
    wr(ct_a[0], 8'h04);
    @(posedge clock);
    ep_int_en <= 4'hf;
    fork
      i_host.send_ev(0, eps_ev_out);
      wr(ct_a[0], 8'h02);
    join
    rd(st_a[0], 8'h02);
    $display("test iso_mask_race done");
    wr(ct_a[1], 8'h70);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk({resp_valid, ep_irq, resp_code}, {1'b0, 4'h0, eps_resp_nak});
    rd(ct_a[1], 8'h00);
    rd(st_a[0], 8'h00);
    $display("test mid_reset done");
    end_sim();
  end
endmodule
`default_nettype wire
